// ===== core/shs_homing_sequencer.sv
// Homing sequencer with APB register slave
// Behaviour
// R1 - Refuse homing unless home input, or encoder with index homing, is configured
// R2 - Counter-clockwise command runs the same profile with directions inverted
// R3 - Without approach flag, accelerate then run programmed speed until home active
// R4 - Home active in first run: decelerate, stop, dwell two seconds
// R5 - After dwell run reverse until home releases, then decelerate, stop, dwell
// R6 - Final approach at starting speed, stop when home goes active
// R7 - Home already active at command: start at reverse run
// R8 - With approach flag configured, ignore sensor until flag rises
// R9 - After flag rise, next sensor activation is home even if flag dropped
// R10 - Host drives approach flag itself; leaves it unused for sensor-only homing
// R11 - Proximity: decelerate on approach active, stop when sensor activates
// R12 - Starting speed is the floor; keep running there if reached
// R13 - With index homing, home input acts as hardware approach signal
// R14 - Limit in travel direction: stop, dwell, then reverse run and approach
// R15 - Opposite limit during homing: stop at once and set fault; code does so only while dir_cw equals the commanded direction
// R16 - Both limits active during search: stop and report error
// R17 - Travel limit already active at command: begin at reverse run
// R18 - At home point clear motor position, and encoder position if enabled
// R19 - Search starts in commanded direction and ends moving that way slowly
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "shs_params.svh"
module shs_homing_sequencer #(
	parameter int unsigned DWELL_CYC = `SHS_DWELL_CYC,
	parameter int unsigned SPEED_W = `SHS_SPEED_W
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic home_sensor,
	input wire logic index_pulse,
	input wire logic clockwise_travel_stop,
	input wire logic counterclockwise_travel_stop,
	output logic moving,
	output logic dir_cw,
	output logic [SPEED_W-1:0] speed,
	output logic clear_motor_pos,
	output logic clear_enc_pos,
	output logic irq
);
	////////////////////////////////////////////////////////////////////////
	shs_pkg::shs_state_e state, next_state;
	logic [3:0] cfg, next_cfg;
	logic [SPEED_W-1:0] start_spd, next_start_spd, prog_spd, next_prog_spd;
	logic [SPEED_W-1:0] next_speed;
	logic [2:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask;
	logic net_prox, next_net_prox, prox_q, next_prox_q, armed, next_armed;
	logic home_q, next_home_q, idx_q, next_idx_q;
	logic cw_cmd, next_cw_cmd, fault, next_fault;
	logic next_moving, next_dir_cw, next_clr_m, next_clr_e;
	logic [31:0] dwell, next_dwell;
	logic [31:0] next_prdata;
	logic wr, rd, cmd_cw, cmd_ccw, can_home, use_prox, prox_src, prox_rise;
	logic home_rise, home_fall, trig, fwd_lim, rev_lim, ev_done, ev_fault, ev_ref;

	function automatic logic [SPEED_W-1:0] ramp(input logic [SPEED_W-1:0] cur,
		input logic [SPEED_W-1:0] tgt);
		if (cur < tgt)
			ramp = cur + SPEED_W'(1);
		else if (cur > tgt)
			ramp = cur - SPEED_W'(1);
		else
			ramp = cur;
	endfunction : ramp

	////////////////////////////////////////////////////////////////////////
	assign wr = psel && penable && pwrite;
	assign rd = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign irq = |(irq_stat & irq_mask);
	assign cmd_cw = wr && paddr == `SHS_REG_CTRL && pwdata[`SHS_CTRL_CW];
	assign cmd_ccw = wr && paddr == `SHS_REG_CTRL && pwdata[`SHS_CTRL_CCW];
	assign can_home = cfg[`SHS_CFG_HOMEIN] || (cfg[`SHS_CFG_ENC] && cfg[`SHS_CFG_INDEX]); // R1
	// Index homing with home input and no approach flag: the input becomes the approach signal
	assign use_prox = cfg[`SHS_CFG_NETPROX] ||
		(cfg[`SHS_CFG_INDEX] && cfg[`SHS_CFG_HOMEIN]); // R13
	assign prox_src = (cfg[`SHS_CFG_INDEX] && cfg[`SHS_CFG_HOMEIN] && !cfg[`SHS_CFG_NETPROX])
		? home_sensor : net_prox; // R13
	assign prox_rise = prox_src && !prox_q; // R8
	assign home_rise = home_sensor && !home_q;
	assign home_fall = !home_sensor && home_q;
	// Homing trigger is index pulse or home sensor edge
	assign trig = cfg[`SHS_CFG_INDEX] ? (index_pulse && !idx_q) : home_rise;
	// Limits swap meaning for the counter-clockwise search
	assign fwd_lim = cw_cmd ? clockwise_travel_stop : counterclockwise_travel_stop; // R2
	assign rev_lim = cw_cmd ? counterclockwise_travel_stop : clockwise_travel_stop; // R2

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		next_state = state;
		next_cfg = cfg;
		next_start_spd = start_spd;
		next_prog_spd = prog_spd;
		next_speed = speed;
		next_irq_mask = irq_mask;
		next_net_prox = net_prox;
		next_prox_q = prox_src;
		next_armed = armed;
		next_home_q = home_sensor;
		next_idx_q = index_pulse;
		next_cw_cmd = cw_cmd;
		next_fault = fault;
		next_moving = moving;
		next_dir_cw = dir_cw;
		next_clr_m = 1'b0;
		next_clr_e = 1'b0;
		next_dwell = dwell;
		ev_done = 1'b0;
		ev_fault = 1'b0;
		ev_ref = 1'b0;
		if (wr && paddr == `SHS_REG_CFG)
			next_cfg = pwdata[3:0];
		if (wr && paddr == `SHS_REG_START)
			next_start_spd = pwdata[SPEED_W-1:0];
		if (wr && paddr == `SHS_REG_PROG)
			next_prog_spd = pwdata[SPEED_W-1:0];
		if (wr && paddr == `SHS_REG_MASK)
			next_irq_mask = pwdata[2:0];
		if (wr && paddr == `SHS_REG_CTRL)
			next_net_prox = pwdata[`SHS_CTRL_PROX]; // R10
		if (prox_rise)
			next_armed = 1'b1; // R9
		unique case (state)
			shs_pkg::SHS_IDLE:
			begin
				next_moving = 1'b0;
				if (cmd_cw || cmd_ccw)
				begin
					if (!can_home)
						ev_ref = 1'b1; // R1
					else
					begin
						next_cw_cmd = cmd_cw;
						next_fault = 1'b0;
						next_armed = 1'b0;
						next_moving = 1'b1;
						next_speed = start_spd;
						// Already on the sensor or the limit in the commanded direction: go straight to the release run
						if (home_sensor || (cmd_cw ? clockwise_travel_stop
							: counterclockwise_travel_stop))
						begin
							next_dir_cw = !cmd_cw; // R7 R17
							next_state = shs_pkg::SHS_BACKOFF;
						end
						else
						begin
							next_dir_cw = cmd_cw; // R19
							next_state = use_prox ? shs_pkg::SHS_APPROACH
								: shs_pkg::SHS_SEEK;
						end
					end
				end
			end
			shs_pkg::SHS_SEEK:
			begin
				next_speed = ramp(speed, prog_spd); // R3
				if (home_sensor)
					next_state = shs_pkg::SHS_DECEL1; // R4
				else if (fwd_lim)
				begin
					next_moving = 1'b0; // R14
					next_speed = start_spd;
					next_dwell = DWELL_CYC;
					next_state = shs_pkg::SHS_DWELL1;
				end
			end
			shs_pkg::SHS_DECEL1:
			begin
				next_speed = ramp(speed, start_spd); // R4
				if (speed == start_spd)
				begin
					next_moving = 1'b0;
					next_dwell = DWELL_CYC;
					next_state = shs_pkg::SHS_DWELL1;
				end
			end
			shs_pkg::SHS_DWELL1:
			begin
				next_dwell = dwell - 32'h0000_0001; // R4
				if (dwell <= 32'h0000_0001)
				begin
					next_moving = 1'b1;
					next_dir_cw = !cw_cmd; // R5
					next_state = shs_pkg::SHS_BACKOFF;
				end
			end
			shs_pkg::SHS_BACKOFF:
			begin
				next_speed = ramp(speed, prog_spd); // R5
				// Off the sensor (limit start) the run must cross it before it can end
				if (home_fall)
					next_state = shs_pkg::SHS_DECEL2; // R5 R14 R17
			end
			shs_pkg::SHS_DECEL2:
			begin
				next_speed = ramp(speed, start_spd);
				if (speed == start_spd)
				begin
					next_moving = 1'b0;
					next_dwell = DWELL_CYC;
					next_state = shs_pkg::SHS_DWELL2;
				end
			end
			shs_pkg::SHS_DWELL2:
			begin
				next_dwell = dwell - 32'h0000_0001;
				if (dwell <= 32'h0000_0001)
				begin
					next_moving = 1'b1;
					next_dir_cw = cw_cmd; // R6 R19
					next_speed = start_spd;
					next_state = shs_pkg::SHS_FINAL;
				end
			end
			shs_pkg::SHS_FINAL:
			begin
				next_speed = start_spd; // R6
				if (trig)
				begin
					next_moving = 1'b0;
					next_clr_m = 1'b1; // R18
					next_clr_e = cfg[`SHS_CFG_ENC]; // R18
					ev_done = 1'b1;
					next_state = shs_pkg::SHS_IDLE;
				end
			end
			shs_pkg::SHS_APPROACH:
			begin
				// Ramp down after arming; the start speed floor holds
				next_speed = (armed || prox_rise) ? ramp(speed, start_spd)
					: ramp(speed, prog_spd); // R11 R12
				if (armed && trig)
				begin
					next_moving = 1'b0; // R9 R11
					next_clr_m = 1'b1; // R18
					next_clr_e = cfg[`SHS_CFG_ENC];
					ev_done = 1'b1;
					next_state = shs_pkg::SHS_IDLE;
				end
				else if (fwd_lim)
				begin
					next_moving = 1'b0; // R14
					next_dwell = DWELL_CYC;
					next_state = shs_pkg::SHS_DWELL1;
				end
			end
			default:
				next_state = shs_pkg::SHS_IDLE;
		endcase
		// Fault stops override every searching state
		if (state != shs_pkg::SHS_IDLE && ((clockwise_travel_stop &&
			counterclockwise_travel_stop) || (rev_lim && dir_cw == cw_cmd)))
		begin
			next_moving = 1'b0; // R15 R16
			next_fault = 1'b1;
			next_clr_m = 1'b0;
			next_clr_e = 1'b0;
			ev_done = 1'b0;
			ev_fault = 1'b1;
			next_state = shs_pkg::SHS_IDLE;
		end
		if (!next_moving)
			next_speed = start_spd;
	end

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		next_irq_stat = irq_stat;
		if (wr && paddr == `SHS_REG_IRQ)
			next_irq_stat = irq_stat & ~pwdata[2:0];
		// Set wins over a simultaneous clear
		next_irq_stat[`SHS_IRQ_DONE] = next_irq_stat[`SHS_IRQ_DONE] | ev_done;
		next_irq_stat[`SHS_IRQ_FAULT] = next_irq_stat[`SHS_IRQ_FAULT] | ev_fault;
		next_irq_stat[`SHS_IRQ_REFUSED] = next_irq_stat[`SHS_IRQ_REFUSED] | ev_ref;
		next_prdata = prdata;
		if (rd)
		begin
			unique case (paddr)
				`SHS_REG_CFG: next_prdata = {28'h0, cfg};
				`SHS_REG_START: next_prdata = 32'(start_spd);
				`SHS_REG_PROG: next_prdata = 32'(prog_spd);
				`SHS_REG_STAT: next_prdata = {20'h0, fault, armed, net_prox, state,
					dir_cw, moving, clockwise_travel_stop, counterclockwise_travel_stop,
					home_sensor};
				`SHS_REG_IRQ: next_prdata = {29'h0, irq_stat};
				`SHS_REG_MASK: next_prdata = {29'h0, irq_mask};
				`SHS_REG_SPEED: next_prdata = 32'(speed);
				default: next_prdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= shs_pkg::SHS_IDLE;
			cfg <= 4'h0;
			start_spd <= '0;
			prog_spd <= '0;
			speed <= '0;
			irq_stat <= 3'h0;
			irq_mask <= 3'h0;
			net_prox <= 1'b0;
			prox_q <= 1'b0;
			armed <= 1'b0;
			home_q <= 1'b0;
			idx_q <= 1'b0;
			cw_cmd <= 1'b1;
			fault <= 1'b0;
			moving <= 1'b0;
			dir_cw <= 1'b1;
			clear_motor_pos <= 1'b0;
			clear_enc_pos <= 1'b0;
			dwell <= 32'h0000_0000;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			state <= next_state;
			cfg <= next_cfg;
			start_spd <= next_start_spd;
			prog_spd <= next_prog_spd;
			speed <= next_speed;
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
			net_prox <= next_net_prox;
			prox_q <= next_prox_q;
			armed <= next_armed;
			home_q <= next_home_q;
			idx_q <= next_idx_q;
			cw_cmd <= next_cw_cmd;
			fault <= next_fault;
			moving <= next_moving;
			dir_cw <= next_dir_cw;
			clear_motor_pos <= next_clr_m;
			clear_enc_pos <= next_clr_e;
			dwell <= next_dwell;
			prdata <= next_prdata;
		end
	end
endmodule : shs_homing_sequencer

// ===== core/shs_params.svh
// Offsets, fields and timing constants of the homing sequencer
`ifndef SHS_PARAMS_SVH
`define SHS_PARAMS_SVH
`define SHS_REG_CTRL 12'h000
`define SHS_REG_CFG 12'h004
`define SHS_REG_START 12'h008
`define SHS_REG_PROG 12'h00c
`define SHS_REG_STAT 12'h010
`define SHS_REG_IRQ 12'h014
`define SHS_REG_MASK 12'h018
`define SHS_REG_SPEED 12'h01c
`define SHS_CTRL_CW 0
`define SHS_CTRL_CCW 1
`define SHS_CTRL_PROX 2
`define SHS_CFG_HOMEIN 0
`define SHS_CFG_ENC 1
`define SHS_CFG_INDEX 2
`define SHS_CFG_NETPROX 3
`define SHS_IRQ_DONE 0
`define SHS_IRQ_FAULT 1
`define SHS_IRQ_REFUSED 2
`define SHS_DWELL_MS 2000
`define SHS_CLK_MHZ 100
`define SHS_DWELL_CYC (`SHS_DWELL_MS * 1000 * `SHS_CLK_MHZ)
`define SHS_SPEED_W 16
`endif

// ===== core/shs_pkg.sv
// Types of the homing sequencer
package shs_pkg;
	typedef enum logic [3:0] {
		SHS_IDLE = 4'h0,
		SHS_SEEK = 4'h1,
		SHS_DECEL1 = 4'h2,
		SHS_DWELL1 = 4'h3,
		SHS_BACKOFF = 4'h4,
		SHS_DECEL2 = 4'h5,
		SHS_DWELL2 = 4'h6,
		SHS_FINAL = 4'h7,
		SHS_APPROACH = 4'h8
	} shs_state_e;
endpackage : shs_pkg

// ===== tb/shs_axis_model.sv
// Behavioural axis: position, home window, index mark, travel stops
`timescale 1ns/1ps
module shs_axis_model (
	input wire logic pclk,
	input wire logic moving,
	input wire logic dir_cw,
	input wire logic load,
	input wire logic signed [31:0] load_pos,
	input wire logic home_force,
	input wire logic both_lim,
	output int pos,
	output logic home_sensor,
	output logic index_pulse,
	output logic clockwise_travel_stop,
	output logic counterclockwise_travel_stop
);
	// One step a cycle; only the order of events matters here
	always_ff @(posedge pclk)
	begin
		if (load)
			pos <= load_pos;
		else if (moving)
			pos <= dir_cw ? pos + 1 : pos - 1;
	end
	assign home_sensor = home_force || (pos >= 20 && pos <= 40);
	assign index_pulse = (pos & 7) == 1;
	assign clockwise_travel_stop = both_lim || pos >= 100;
	assign counterclockwise_travel_stop = both_lim || pos <= -100;
endmodule : shs_axis_model

// ===== tb/shs_homing_chk.sv
// Port assertions of the homing sequencer
`timescale 1ns/1ps
module shs_homing_chk #(
	parameter int unsigned DWELL_CYC = 20,
	parameter int unsigned SPEED_W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic home_sensor,
	input wire logic index_pulse,
	input wire logic clockwise_travel_stop,
	input wire logic counterclockwise_travel_stop,
	input wire logic moving,
	input wire logic dir_cw,
	input wire logic [SPEED_W-1:0] speed,
	input wire logic clear_motor_pos,
	input wire logic clear_enc_pos,
	input wire logic irq
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_run;
		moving ##1 moving;
	endsequence
	a_pulse_one: assert property (clear_motor_pos |=> !clear_motor_pos)
		else $error("position clear longer than one cycle");
	a_enc_pair: assert property (clear_enc_pos |-> clear_motor_pos)
		else $error("encoder clear without motor clear");
	a_home_stop: assert property (clear_motor_pos |=> !moving)
		else $error("still moving after home point");
	a_both_stop: assert property (clockwise_travel_stop && counterclockwise_travel_stop
		|-> ##[0:3] !moving)
		else $error("no stop with both travel stops");
	a_ramp_step: assert property (s_run |-> (speed == $past(speed))
		|| (speed == $past(speed) + 1'b1) || (speed == $past(speed) - 1'b1))
		else $error("speed jumped");
	a_dir_hold: assert property (s_run |-> $stable(dir_cw))
		else $error("direction changed while moving");
	a_cw_stop: assert property (moving && dir_cw && clockwise_travel_stop
		|-> ##[1:3] !moving)
		else $error("ran into clockwise stop");
	a_dwell_gap: assert property ($fell(moving) |-> (!moving)[*8])
		else $error("restart without dwell");
	a_apb_ok: assert property (psel && !penable && !pwrite && paddr == 12'h3fc
		|=> pready && !pslverr && prdata == 32'h0000_0000)
		else $error("bad answer to unmapped read");
endmodule : shs_homing_chk

bind shs_homing_sequencer shs_homing_chk #(.DWELL_CYC(DWELL_CYC), .SPEED_W(SPEED_W)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.home_sensor(home_sensor), .index_pulse(index_pulse),
	.clockwise_travel_stop(clockwise_travel_stop),
	.counterclockwise_travel_stop(counterclockwise_travel_stop), .moving(moving),
	.dir_cw(dir_cw), .speed(speed), .clear_motor_pos(clear_motor_pos),
	.clear_enc_pos(clear_enc_pos), .irq(irq));

// ===== tb/tb_top.sv
// Self-checking bench of the homing sequencer
`timescale 1ns/1ps
`include "shs_params.svh"
module tb_top;
	typedef struct {logic [31:0] cfg; logic [31:0] cmd; int p; logic [31:0] st; int lo;} shs_row_s;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, home_sensor, index_pulse, cw_stop, ccw_stop;
	logic moving, dir_cw, clear_motor_pos, clear_enc_pos, irq;
	logic [15:0] speed;
	logic load = 1'b0;
	logic home_force = 1'b0;
	logic both_lim = 1'b0;
	logic clr_seen = 1'b0;
	logic enc_seen = 1'b0;
	int load_pos = 0;
	int pos;
	int fail_count = 0;
	int n_tests = 0;
	int cyc = 0;
	// Table runs, one fault and one refusal among them: config, command, start position, status, lowest final position
	shs_row_s rows [8] = '{'{32'h1, 32'h1, 0, 32'h1, 20}, '{32'h1, 32'h2, 60, 32'h1, 37},
		'{32'h1, 32'h3, 30, 32'h1, 20}, '{32'h1, 32'h1, 60, 32'h1, 20},
		'{32'h1, 32'h1, 100, 32'h1, 20}, '{32'h7, 32'h1, 0, 32'h1, 25},
		'{32'h1, 32'h1, -100, 32'h2, -100}, '{32'h2, 32'h1, 0, 32'h4, 0}};
	shs_homing_sequencer #(.DWELL_CYC(20)) u_shs_homing_sequencer (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.home_sensor(home_sensor), .index_pulse(index_pulse), .clockwise_travel_stop(cw_stop),
		.counterclockwise_travel_stop(ccw_stop), .moving(moving), .dir_cw(dir_cw),
		.speed(speed), .clear_motor_pos(clear_motor_pos), .clear_enc_pos(clear_enc_pos),
		.irq(irq));
	shs_axis_model u_shs_axis_model (.pclk(pclk), .moving(moving), .dir_cw(dir_cw),
		.load(load), .load_pos(load_pos), .home_force(home_force), .both_lim(both_lim),
		.pos(pos), .home_sensor(home_sensor), .index_pulse(index_pulse),
		.clockwise_travel_stop(cw_stop), .counterclockwise_travel_stop(ccw_stop));
	always #5 pclk = ~pclk;
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (clear_motor_pos)
			clr_seen <= 1'b1;
		if (clear_enc_pos)
			enc_seen <= 1'b1;
		if (cyc == 30000)
		begin
			fail_count++;
			end_of_test();
		end
	end
	task end_of_test;
		if (fail_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// An idle cycle before each setup keeps every signal to one update a step
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task go(input logic [31:0] cfg, input int p, input logic [31:0] cmd);
		load_pos <= p;
		load <= 1'b1;
		@(posedge pclk);
		load <= 1'b0;
		clr_seen = 1'b0;
		enc_seen = 1'b0;
		apb(1'b1, `SHS_REG_CFG, cfg);
		apb(1'b1, `SHS_REG_IRQ, 32'h7);
		apb(1'b1, `SHS_REG_CTRL, cmd);
	endtask : go
	task wait_irq;
		while (irq !== 1'b1)
			@(posedge pclk);
		apb(1'b0, `SHS_REG_IRQ, 32'h0);
	endtask : wait_irq
	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `SHS_REG_MASK, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, `SHS_REG_START, 32'h4);
		apb(1'b1, `SHS_REG_PROG, 32'ha);
		apb(1'b1, `SHS_REG_MASK, 32'h7);
		foreach (rows[i])
		begin
			go(rows[i].cfg, rows[i].p, rows[i].cmd);
			wait_irq();
			chk(rd, rows[i].st);
			chk(32'(pos >= rows[i].lo && pos <= rows[i].lo + 3), 32'h1);
			chk(32'(moving), 32'h0);
			chk(32'(speed), 32'h4);
			chk(32'(clr_seen), 32'(rows[i].st == 1));
			chk(32'(enc_seen), 32'(rows[i].st == 1 && rows[i].cfg[1]));
			if (rows[i].st == 1)
				chk(32'(dir_cw), 32'(rows[i].cmd[0]));
		end
		go(32'h9, -60, 32'h1);
		while (pos < -40)
			@(posedge pclk);
		home_force <= 1'b1;
		repeat (3) @(posedge pclk);
		home_force <= 1'b0;
		while (pos < -20)
			@(posedge pclk);
		chk(32'(moving), 32'h1);
		apb(1'b1, `SHS_REG_CTRL, 32'h4);
		apb(1'b1, `SHS_REG_CTRL, 32'h0);
		wait_irq();
		chk(32'(pos >= 20 && pos <= 23), 32'h1);
		go(32'h1, 0, 32'h1);
		repeat (5) @(posedge pclk);
		both_lim <= 1'b1;
		wait_irq();
		chk(rd, 32'h2);
		both_lim <= 1'b0;
		apb(1'b1, `SHS_REG_MASK, 32'h0);
		go(32'h0, 0, 32'h1);
		chk(32'(irq), 32'h0);
		apb(1'b0, `SHS_REG_IRQ, 32'h0);
		chk(rd, 32'h4);
		apb(1'b1, `SHS_REG_MASK, 32'h7);
		// Mask and status settle after the access edge
		@(negedge pclk);
		chk(32'(irq), 32'h1);
		apb(1'b1, `SHS_REG_IRQ, 32'h4);
		@(negedge pclk);
		chk(32'(irq), 32'h0);
		// Reset in mid-search
		go(32'h1, 0, 32'h1);
		repeat (4) @(posedge pclk);
		presetn <= 1'b0;
		@(negedge pclk);
		chk(32'({moving, dir_cw, irq, clear_motor_pos, clear_enc_pos}), 32'h8);
		chk(32'(speed), 32'h0);
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h3fc, 32'h0);
		chk(rd, 32'h0);
		end_of_test();
	end
endmodule : tb_top
